// *** design/rpia_port.sv ***
/*
 rpia_port: status latching for one receive port; builds both port status
 registers and the interrupt status copies, clears latched bits on read.
 Assumes condition inputs are synchronous to ref_clk_i; error inputs are
 one-cycle or level events, lock and pass are levels.
*/
`timescale 1ns/1ps
module rpia_port
   import rpia_pkg::*;
#(
   parameter logic [1:0] PORT_NUM = 2'h0
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_b_i,
   // link conditions
   input  wire logic             link_locked_i,
   input  wire logic             pass_i,
   input  wire logic             link_parity_err_i,
   input  wire logic             link_encode_err_i,
   input  wire logic             backchan_checksum_err_i,
   input  wire logic             backchan_sequence_err_i,
   input  wire logic             rate_stable_i,
   input  wire logic             link_clock_missing_i,
   // read-clear strobes
   input  wire logic             rd_sts1_i,
   input  wire logic             rd_sts2_i,
   // register views
   output logic      [7:0]       sts1_o,
   output logic      [7:0]       sts2_o,
   output logic      [IRQ_W-1:0] isr_hi_o,
   output logic      [IRQ_W-1:0] isr_lo_o
);
   logic lock_q_reg;
   logic crc_reg;
   logic seq_reg;
   logic par_reg;
   logic lockchg_reg;
   logic enc_reg;
   logic lock_edge;

   assign lock_edge = link_locked_i ^ lock_q_reg;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_q_reg <= 1'b0;
      end else begin
         lock_q_reg <= link_locked_i;
      end
   end

   // set beats a same-cycle read so no event is lost
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         crc_reg     <= 1'b0;
         seq_reg     <= 1'b0;
         par_reg     <= 1'b0;
         lockchg_reg <= 1'b0;
         enc_reg     <= 1'b0;
      end else begin
         crc_reg     <= backchan_checksum_err_i | (crc_reg & ~rd_sts1_i);
         seq_reg     <= backchan_sequence_err_i | (seq_reg & ~rd_sts1_i);
         par_reg     <= link_parity_err_i | (par_reg & ~rd_sts1_i);
         lockchg_reg <= lock_edge | (lockchg_reg & ~rd_sts1_i);
         enc_reg     <= link_encode_err_i | (enc_reg & ~rd_sts2_i);
      end
   end

   always_comb begin
      sts1_o                           = 8'h00;
      sts1_o[S1_PORT_LSB +: 2]         = PORT_NUM;
      sts1_o[S1_CRC]                   = crc_reg;
      sts1_o[S1_LOCKCHG]               = lockchg_reg;
      sts1_o[S1_SEQ]                   = seq_reg;
      sts1_o[S1_PAR]                   = par_reg;
      sts1_o[S1_PASS]                  = pass_i;
      sts1_o[S1_LOCK]                  = link_locked_i;
      sts2_o                           = 8'h00;
      sts2_o[S2_ENC]                   = enc_reg;
      sts2_o[S2_STABLE]                = rate_stable_i;
      sts2_o[S2_NOCLK]                 = link_clock_missing_i;
      // copies of the main status bits; lock source is the latched change
      isr_lo_o                         = '0;
      isr_lo_o[ISR_LO_PAR]             = par_reg;
      isr_lo_o[ISR_LO_PASS]            = pass_i;
      isr_lo_o[ISR_LO_LOCK]            = lockchg_reg;
      isr_hi_o                         = '0;
      isr_hi_o[ISR_HI_ENC]             = enc_reg;
      isr_hi_o[ISR_HI_SEQ]             = seq_reg;
      isr_hi_o[ISR_HI_CRC]             = crc_reg;
   end
endmodule // rpia_port

// *** design/rpia_top.sv ***
/*
 rpia_top: receive-port interrupt aggregator with its serial control bus
 slave, global and paged per-port registers and the active-low interrupt pin.
 Assumes scl_i/sda_i are already synchronous to ref_clk_i and that the
 outside wire is open drain: sda_oe_o high pulls the line low.
*/
// Function
// - pin driven from control, status aggregated
// - status bits set regardless of enables
// - pin needs port enable and global enable
// - status shown even with global enable clear
// - interrupt pin active low
// - only reading source status clears it
// - per-port enable registers high and low
// - per-port status copies, read only
// - port status reads clear port conditions
// - global status: bit7 global, bits1:0 ports
// - control: bit7 pin, bits1:0 ports
// - low status: parity, pass, lock
// - high status: encode, sequence, checksum
// - first status register fields, clear on read
// - second status register fields
// - page select routes per-port accesses
// - acknowledge address match and written bytes
// - latched bits hold until read
`timescale 1ns/1ps
module rpia_top
   import rpia_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR  = 7'h3D,
   parameter int         NUM_PORTS = 2
) (
   // clock and reset
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_b_i,
   // serial control bus, open drain
   input  wire logic                 scl_i,
   input  wire logic                 sda_i,
   output logic                      sda_o,
   output logic                      sda_oe_o,
   // link conditions, one bit per port
   input  wire logic [NUM_PORTS-1:0] link_locked_i,
   input  wire logic [NUM_PORTS-1:0] pass_i,
   input  wire logic [NUM_PORTS-1:0] link_parity_err_i,
   input  wire logic [NUM_PORTS-1:0] link_encode_err_i,
   input  wire logic [NUM_PORTS-1:0] backchan_checksum_err_i,
   input  wire logic [NUM_PORTS-1:0] backchan_sequence_err_i,
   input  wire logic [NUM_PORTS-1:0] rate_stable_i,
   input  wire logic [NUM_PORTS-1:0] link_clock_missing_i,
   // interrupt pin
   output logic                      irq_out_n_o
);
   // bus engine state
   rpia_bus_st_t   state_reg;
   logic [3:0]     cnt_reg;
   logic [7:0]     sh_reg;
   logic [7:0]     tx_reg;
   logic [7:0]     ptr_reg;
   logic           rnw_reg;
   logic           mack_reg;
   logic           drive_reg;
   logic           scl_q_reg;
   logic           sda_q_reg;
   // edges and strobes
   logic           scl_rise;
   logic           scl_fall;
   logic           start_cond;
   logic           stop_cond;
   logic           byte_end;
   logic           wr_stb;
   logic           rd_stb;
   logic [7:0]     rdata;
   // registers
   logic                 pin_en_reg;
   logic [NUM_PORTS-1:0] port_ie_reg;
   logic [7:0]           page_reg;
   logic [IRQ_W-1:0]     icr_hi_reg [NUM_PORTS];
   logic [IRQ_W-1:0]     icr_lo_reg [NUM_PORTS];
   // per-port views
   logic [7:0]           sts1   [NUM_PORTS];
   logic [7:0]           sts2   [NUM_PORTS];
   logic [IRQ_W-1:0]     isr_hi [NUM_PORTS];
   logic [IRQ_W-1:0]     isr_lo [NUM_PORTS];
   logic [NUM_PORTS-1:0] port_pending;
   logic [NUM_PORTS-1:0] rd_sts1;
   logic [NUM_PORTS-1:0] rd_sts2;
   logic                 global_pending;
   int                   rd_port;

   // offsets routed through the port page
   function automatic logic is_paged(input logic [7:0] ofs);
      is_paged = (ofs == OFS_STS1) || (ofs == OFS_STS2) ||
                 (ofs == OFS_ICR_HI) || (ofs == OFS_ICR_LO) ||
                 (ofs == OFS_ISR_HI) || (ofs == OFS_ISR_LO);
   endfunction

   // a write reaches every port whose page write bit is set
   function automatic logic page_wr_hit(input logic [7:0] page, input int p);
      page_wr_hit = page[p];
   endfunction

   // bus line sampling
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl_i;
         sda_q_reg <= sda_i;
      end
   end

   assign scl_rise   = scl_i & ~scl_q_reg;
   assign scl_fall   = ~scl_i & scl_q_reg;
   assign start_cond = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
   assign stop_cond  = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
   assign byte_end   = scl_fall & (cnt_reg == BITS_PER_BYTE);
   assign wr_stb     = byte_end & (state_reg == ST_WDATA);
   // read data is fetched, and status cleared, only when a byte is loaded
   assign rd_stb     = scl_fall & (((state_reg == ST_ADDR_ACK) & rnw_reg) |
                                   ((state_reg == ST_RDATA_ACK) & mack_reg));

   // open drain: data output is fixed low, the enable does the signalling
   assign sda_o    = 1'b0;
   assign sda_oe_o = drive_reg;

   // serial bus slave engine
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 4'h0;
         sh_reg    <= 8'h00;
         tx_reg    <= 8'h00;
         ptr_reg   <= 8'h00;
         rnw_reg   <= 1'b0;
         mack_reg  <= 1'b0;
         drive_reg <= 1'b0;
      end else if (start_cond) begin
         state_reg <= ST_ADDR;
         cnt_reg   <= 4'h0;
         drive_reg <= 1'b0;
      end else if (stop_cond) begin
         state_reg <= ST_IDLE;
         drive_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               drive_reg <= 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  sh_reg  <= {sh_reg[6:0], sda_i};
                  cnt_reg <= cnt_reg + BIT_ONE;
               end else if (byte_end) begin
                  cnt_reg <= 4'h0;
                  if (sh_reg[7:1] == DEV_ADDR) begin
                     rnw_reg   <= sh_reg[0];
                     drive_reg <= 1'b1;
                     state_reg <= ST_ADDR_ACK;
                  end else begin
                     drive_reg <= 1'b0;
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_PTR: begin
               if (scl_rise) begin
                  sh_reg  <= {sh_reg[6:0], sda_i};
                  cnt_reg <= cnt_reg + BIT_ONE;
               end else if (byte_end) begin
                  cnt_reg   <= 4'h0;
                  ptr_reg   <= sh_reg;
                  drive_reg <= 1'b1;
                  state_reg <= ST_PTR_ACK;
               end
            end
            ST_WDATA: begin
               if (scl_rise) begin
                  sh_reg  <= {sh_reg[6:0], sda_i};
                  cnt_reg <= cnt_reg + BIT_ONE;
               end else if (byte_end) begin
                  cnt_reg   <= 4'h0;
                  drive_reg <= 1'b1;
                  state_reg <= ST_WDATA_ACK;
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rnw_reg) begin
                     tx_reg    <= rdata;
                     drive_reg <= ~rdata[7];
                     cnt_reg   <= BIT_ONE;
                     ptr_reg   <= ptr_reg + 8'h01;
                     state_reg <= ST_RDATA;
                  end else begin
                     drive_reg <= 1'b0;
                     state_reg <= ST_PTR;
                  end
               end
            end
            ST_PTR_ACK: begin
               if (scl_fall) begin
                  drive_reg <= 1'b0;
                  state_reg <= ST_WDATA;
               end
            end
            ST_WDATA_ACK: begin
               if (scl_fall) begin
                  drive_reg <= 1'b0;
                  ptr_reg   <= ptr_reg + 8'h01;
                  state_reg <= ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (cnt_reg == BITS_PER_BYTE) begin
                     drive_reg <= 1'b0;
                     state_reg <= ST_RDATA_ACK;
                  end else begin
                     drive_reg <= ~tx_reg[6];
                     tx_reg    <= {tx_reg[6:0], 1'b0};
                     cnt_reg   <= cnt_reg + BIT_ONE;
                  end
               end
            end
            ST_RDATA_ACK: begin
               // host acks to continue, nacks the last byte
               if (scl_rise) begin
                  mack_reg <= ~sda_i;
               end else if (scl_fall) begin
                  if (mack_reg) begin
                     tx_reg    <= rdata;
                     drive_reg <= ~rdata[7];
                     cnt_reg   <= BIT_ONE;
                     ptr_reg   <= ptr_reg + 8'h01;
                     state_reg <= ST_RDATA;
                  end else begin
                     drive_reg <= 1'b0;
                     state_reg <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // global registers; control is not paged
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_en_reg  <= 1'b0;
         port_ie_reg <= '0;
         page_reg    <= RST_PAGE;
      end else if (wr_stb) begin
         if (ptr_reg == OFS_GCTL) begin
            pin_en_reg  <= sh_reg[GCTL_PIN_EN];
            port_ie_reg <= sh_reg[NUM_PORTS-1:0];
         end
         if (ptr_reg == OFS_PAGE) begin
            page_reg <= sh_reg;
         end
      end
   end

   // reads follow the page read select
   assign rd_port = int'(page_reg[PAGE_RD_LSB]);

   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         // enables written to each port selected for writing
         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               icr_hi_reg[gp] <= RST_ICR;
               icr_lo_reg[gp] <= RST_ICR;
            end else if (wr_stb && page_wr_hit(page_reg, gp)) begin
               if (ptr_reg == OFS_ICR_HI) begin
                  icr_hi_reg[gp] <= sh_reg[IRQ_W-1:0];
               end
               if (ptr_reg == OFS_ICR_LO) begin
                  icr_lo_reg[gp] <= sh_reg[IRQ_W-1:0];
               end
            end
         end

         // only a read of the selected port's status clears it
         assign rd_sts1[gp] = rd_stb && (ptr_reg == OFS_STS1) && (rd_port == gp);
         assign rd_sts2[gp] = rd_stb && (ptr_reg == OFS_STS2) && (rd_port == gp);

         rpia_port #(
            .PORT_NUM (2'(gp))
         ) u_port (
            .ref_clk_i               (ref_clk_i),
            .rst_b_i                 (rst_b_i),
            .link_locked_i           (link_locked_i[gp]),
            .pass_i                  (pass_i[gp]),
            .link_parity_err_i       (link_parity_err_i[gp]),
            .link_encode_err_i       (link_encode_err_i[gp]),
            .backchan_checksum_err_i (backchan_checksum_err_i[gp]),
            .backchan_sequence_err_i (backchan_sequence_err_i[gp]),
            .rate_stable_i           (rate_stable_i[gp]),
            .link_clock_missing_i    (link_clock_missing_i[gp]),
            .rd_sts1_i               (rd_sts1[gp]),
            .rd_sts2_i               (rd_sts2[gp]),
            .sts1_o                  (sts1[gp]),
            .sts2_o                  (sts2[gp]),
            .isr_hi_o                (isr_hi[gp]),
            .isr_lo_o                (isr_lo[gp])
         );

         // pending drops as soon as no enabled source remains
         assign port_pending[gp] = |(isr_hi[gp] & icr_hi_reg[gp]) |
                                   |(isr_lo[gp] & icr_lo_reg[gp]);
      end
   endgenerate

   // port flag gated by its control enable, not by the pin enable
   assign global_pending = |(port_pending & port_ie_reg);

   // pin is low only with pin enable set and a pending port
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_out_n_o <= 1'b1;
      end else begin
         irq_out_n_o <= ~(pin_en_reg & global_pending);
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rdata = 8'h00;
      if (is_paged(ptr_reg)) begin
         unique case (ptr_reg)
            OFS_STS1:   rdata = sts1[rd_port];
            OFS_STS2:   rdata = sts2[rd_port];
            OFS_ICR_HI: rdata = {5'h00, icr_hi_reg[rd_port]};
            OFS_ICR_LO: rdata = {5'h00, icr_lo_reg[rd_port]};
            OFS_ISR_HI: rdata = {5'h00, isr_hi[rd_port]};
            OFS_ISR_LO: rdata = {5'h00, isr_lo[rd_port]};
            default:    rdata = 8'h00;
         endcase
      end else if (ptr_reg == OFS_GCTL) begin
         rdata[GCTL_PIN_EN]     = pin_en_reg;
         rdata[NUM_PORTS-1:0]   = port_ie_reg;
      end else if (ptr_reg == OFS_GSTS) begin
         rdata[GSTS_GLOBAL]     = global_pending;
         rdata[NUM_PORTS-1:0]   = port_pending;
      end else if (ptr_reg == OFS_PAGE) begin
         rdata = page_reg;
      end
   end
endmodule // rpia_top

// *** inc/rpia_pkg.sv ***
/*
 rpia_pkg: register offsets, field positions, reset values and bus engine
 states for the receive-port interrupt aggregator.
 Assumes an 8-bit register space reached over the serial control bus.
*/
package rpia_pkg;
   // register offsets
   localparam logic [7:0] OFS_GCTL   = 8'h23;
   localparam logic [7:0] OFS_GSTS   = 8'h24;
   localparam logic [7:0] OFS_PAGE   = 8'h4C;
   localparam logic [7:0] OFS_STS1   = 8'h4D;
   localparam logic [7:0] OFS_STS2   = 8'h4E;
   localparam logic [7:0] OFS_ICR_HI = 8'hD8;
   localparam logic [7:0] OFS_ICR_LO = 8'hD9;
   localparam logic [7:0] OFS_ISR_HI = 8'hDA;
   localparam logic [7:0] OFS_ISR_LO = 8'hDB;
   // global control and status fields
   localparam int GCTL_PIN_EN = 7;
   localparam int GSTS_GLOBAL = 7;
   localparam int PAGE_RD_LSB = 4;
   // first port status fields
   localparam int S1_PORT_LSB = 6;
   localparam int S1_CRC      = 5;
   localparam int S1_LOCKCHG  = 4;
   localparam int S1_SEQ      = 3;
   localparam int S1_PAR      = 2;
   localparam int S1_PASS     = 1;
   localparam int S1_LOCK     = 0;
   // second port status fields
   localparam int S2_ENC      = 5;
   localparam int S2_STABLE   = 2;
   localparam int S2_NOCLK    = 1;
   // per-port interrupt enable and status fields
   localparam int IRQ_W       = 3;
   localparam int ISR_LO_PAR  = 2;
   localparam int ISR_LO_PASS = 1;
   localparam int ISR_LO_LOCK = 0;
   localparam int ISR_HI_ENC  = 2;
   localparam int ISR_HI_SEQ  = 1;
   localparam int ISR_HI_CRC  = 0;
   // reset values
   localparam logic [7:0]       RST_PAGE = 8'h01;
   localparam logic [IRQ_W-1:0] RST_ICR  = 3'h0;
   // serial bus byte length
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_ONE       = 4'h1;

   typedef enum logic [8:0] {
      ST_IDLE      = 9'h001,
      ST_ADDR      = 9'h002,
      ST_ADDR_ACK  = 9'h004,
      ST_PTR       = 9'h008,
      ST_PTR_ACK   = 9'h010,
      ST_WDATA     = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA     = 9'h080,
      ST_RDATA_ACK = 9'h100
   } rpia_bus_st_t;
endpackage

// *** tb/rpia_checker.sv ***
/*
 rpia_checker: port-level assertions for the interrupt aggregator top.
 Assumes it is bound to rpia_top and sees one clock domain.
*/
`timescale 1ns/1ps
module rpia_checker #(
   parameter int NUM_PORTS = 2
) (
   // clock, reset, bus
   input wire logic                 ref_clk_i,
   input wire logic                 rst_b_i,
   input wire logic                 scl_i,
   input wire logic                 sda_i,
   input wire logic                 sda_o,
   input wire logic                 sda_oe_o,
   // conditions and pin
   input wire logic [NUM_PORTS-1:0] link_locked_i,
   input wire logic [NUM_PORTS-1:0] pass_i,
   input wire logic [NUM_PORTS-1:0] link_parity_err_i,
   input wire logic [NUM_PORTS-1:0] link_encode_err_i,
   input wire logic [NUM_PORTS-1:0] backchan_checksum_err_i,
   input wire logic [NUM_PORTS-1:0] backchan_sequence_err_i,
   input wire logic                 irq_out_n_o
);
   logic [2*NUM_PORTS-1:0] lvl_reg;
   logic                   ev;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // level history, so a lock or pass edge counts as a cause
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) lvl_reg <= '0;
      else lvl_reg <= {link_locked_i, pass_i};
   end
   assign ev = (|{link_parity_err_i, link_encode_err_i, backchan_checksum_err_i,
                  backchan_sequence_err_i}) | ({link_locked_i, pass_i} != lvl_reg);
   AST_RESET_IDLE: assert property ($rose(rst_b_i) |-> irq_out_n_o && !sda_oe_o)
      else $error("pin or data driver active after reset");
   AST_OPEN_DRAIN: assert property (sda_o == 1'h0)
      else $error("data output not held low");
   AST_OE_AFTER_FALL: assert property ($changed(sda_oe_o) |->
         $past(scl_i, 2) && !$past(scl_i))
      else $error("data driver moved outside clock low phase");
   AST_OE_HOLD: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
      else $error("data driver moved while clock high");
   AST_NO_OWN_START: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe_o)
      else $error("device pulled data low during a start");
   AST_IRQ_RELEASE: assert property ($rose(irq_out_n_o) |-> !$past(scl_i) || $past(ev))
      else $error("pin released without read or level change");
   AST_IRQ_RAISE: assert property ($fell(irq_out_n_o) |->
         !$past(scl_i) || $past(ev) || $past(ev, 2) || $past(ev, 3))
      else $error("pin asserted without cause");
   AST_IRQ_HELD: assert property (scl_i && $past(scl_i) && !$past(ev) && !$past(ev, 2)
         && !$past(ev, 3) |-> $stable(irq_out_n_o))
      else $error("pin moved with no access and no event");
endmodule // rpia_checker

// *** tb/rpia_host_model.sv ***
/*
 rpia_host_model: serial bus master issuing register writes and reads.
 Assumes sda_i and scl_i are the wired line levels with pull-ups.
*/
`timescale 1ns/1ps
module rpia_host_model (
   // bus
   input  wire logic ref_clk_i,
   input  wire logic sda_i,
   input  wire logic scl_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   initial begin
      scl_o = 1'h1;
      sda_oe_o = 1'h0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   // data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_oe_o = ~b;
      wt(4);
      scl_o = 1'h1;
      wt(4);
      while (!scl_i) wt(1); // a stretched clock delays the sample
      r = sda_i;
      scl_o = 1'h0;
      wt(2);
   endtask
   task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                          output logic nk);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(last, nk);
   endtask
   task automatic start();
      sda_oe_o = 1'h0;
      wt(2);
      scl_o = 1'h1;
      wt(4);
      sda_oe_o = 1'h1;
      wt(4);
      scl_o = 1'h0;
      wt(2);
   endtask
   task automatic stop();
      sda_oe_o = 1'h1;
      wt(2);
      scl_o = 1'h1;
      wt(4);
      sda_oe_o = 1'h0;
      wt(4);
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] o, d, output logic nk);
      logic [7:0] q;
      logic       n0, n1, n2;
      start();
      byte_io({a, 1'h0}, 1'h1, q, n0);
      byte_io(o, 1'h1, q, n1);
      byte_io(d, 1'h1, q, n2);
      stop();
      nk = n0 | n1 | n2;
   endtask
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d);
      logic [7:0] q;
      logic       n;
      start();
      byte_io({a, 1'h0}, 1'h1, q, n);
      byte_io(o, 1'h1, q, n);
      start();
      byte_io({a, 1'h1}, 1'h1, q, n);
      byte_io(8'hFF, 1'h1, d, n);
      stop();
   endtask
   task automatic rd_two(input logic [6:0] a, input logic [7:0] o, output logic [15:0] d);
      logic [7:0] q;
      logic       n;
      start();
      byte_io({a, 1'h0}, 1'h1, q, n);
      byte_io(o, 1'h1, q, n);
      start();
      byte_io({a, 1'h1}, 1'h1, q, n);
      byte_io(8'hFF, 1'h0, d[15:8], n);
      byte_io(8'hFF, 1'h1, d[7:0], n);
      stop();
   endtask
   task automatic wr_two(input logic [6:0] a, input logic [7:0] o, d0, d1, output logic nk);
      logic [7:0] q;
      logic [3:0] n;
      start();
      byte_io({a, 1'h0}, 1'h1, q, n[0]);
      byte_io(o, 1'h1, q, n[1]);
      byte_io(d0, 1'h1, q, n[2]);
      byte_io(d1, 1'h1, q, n[3]);
      stop();
      nk = |n;
   endtask
endmodule // rpia_host_model

// *** tb/tb_rpia_top.sv ***
/*
 tb_rpia_top: register-level tests of the interrupt aggregator.
 Assumes the host model as bus master and a pulled-up data line.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_rpia_top
   import rpia_pkg::*;
;
   localparam logic [6:0] ADDR = 7'h3D;
   logic       ref_clk = 1'h0;
   logic       rst_b, scl, dev_oe, host_oe, irq_n, nk;
   wire        sda = ~(dev_oe | host_oe);
   logic [1:0] lock, pass, par, enc, crc, seq, stable, nclk;
   logic [15:0] q16;
   int         mismatches = 0;
   int         n_checks = 0;
   always #12.5 ref_clk = ~ref_clk;
   rpia_top #(.DEV_ADDR(ADDR), .NUM_PORTS(2)) i_rpia_top (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_o(dev_oe), .link_locked_i(lock), .pass_i(pass), .link_parity_err_i(par),
      .link_encode_err_i(enc), .backchan_checksum_err_i(crc),
      .backchan_sequence_err_i(seq), .rate_stable_i(stable), .link_clock_missing_i(nclk),
      .irq_out_n_o(irq_n));
   rpia_host_model i_rpia_host_model (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl),
      .scl_i(scl), .sda_oe_o(host_oe));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] o, d);
      i_rpia_host_model.wr_reg(ADDR, o, d, nk);
      `CHK(nk, 1'h0)
   endtask
   task automatic rd(input logic [7:0] o, exp);
      logic [7:0] q;
      i_rpia_host_model.rd_reg(ADDR, o, q);
      `CHK(q, exp)
   endtask
   task automatic pulse(input logic [1:0] p, e, c, s);
      @(negedge ref_clk) {par, enc, crc, seq} = {p, e, c, s};
      @(negedge ref_clk) {par, enc, crc, seq} = 8'h00;
   endtask
   initial begin
      #2ms;
      mismatches++;
      report_and_stop();
   end
   initial begin
      {lock, pass, par, enc, crc, seq, stable, nclk} = 16'h0000;
      rst_b = 1'h0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) rst_b = 1'h1;
      repeat (2) @(negedge ref_clk);
      `CHK(irq_n, 1'h1)
      rd(OFS_GCTL, 8'h00);
      rd(OFS_PAGE, RST_PAGE);
      i_rpia_host_model.wr_reg(7'h30, OFS_GCTL, 8'h81, nk);
      `CHK(nk, 1'h1)
      $display("test reset and address done");
      pulse(2'h1, 2'h0, 2'h0, 2'h0);
      rd(OFS_ISR_LO, 8'h04);
      rd(OFS_GSTS, 8'h00);
      wr(OFS_ICR_LO, 8'h04);
      rd(OFS_ICR_LO, 8'h04);
      rd(OFS_GSTS, 8'h01);
      wr(OFS_GCTL, 8'h01);
      rd(OFS_GSTS, 8'h81);
      `CHK(irq_n, 1'h1)
      wr(OFS_GCTL, 8'h81);
      `CHK(irq_n, 1'h0)
      wr(OFS_GSTS, 8'h00);
      rd(OFS_GSTS, 8'h81);
      rd(OFS_ISR_LO, 8'h04);
      rd(OFS_STS1, 8'h04);
      `CHK(irq_n, 1'h1)
      rd(OFS_ISR_LO, 8'h00);
      $display("test port zero parity done");
      wr(OFS_PAGE, 8'h12);
      @(negedge ref_clk) {stable, nclk} = 4'hA;
      pulse(2'h0, 2'h2, 2'h2, 2'h2);
      rd(OFS_ISR_HI, 8'h07);
      wr(OFS_ICR_HI, 8'h01);
      wr(OFS_GCTL, 8'h82);
      rd(OFS_GSTS, 8'h82);
      `CHK(irq_n, 1'h0)
      rd(OFS_STS1, 8'h68);
      `CHK(irq_n, 1'h1)
      rd(OFS_ISR_HI, 8'h04);
      rd(OFS_STS2, 8'h26);
      rd(OFS_ISR_HI, 8'h00);
      $display("test port one errors done");
      wr(OFS_PAGE, 8'h01);
      @(negedge ref_clk) {lock, pass} = 4'h5;
      rd(OFS_ISR_LO, 8'h03);
      rd(OFS_ISR_HI, 8'h00);
      rd(OFS_STS1, 8'h13);
      rd(OFS_STS1, 8'h03);
      i_rpia_host_model.wr_two(ADDR, OFS_ICR_HI, 8'h05, 8'h02, nk);
      `CHK(nk, 1'h0)
      rd(OFS_ICR_HI, 8'h05);
      rd(OFS_ICR_LO, 8'h02);
      rd(OFS_GSTS, 8'h01);
      pulse(2'h0, 2'h1, 2'h1, 2'h0);
      i_rpia_host_model.rd_two(ADDR, OFS_STS1, q16);
      `CHK(q16, 16'h2320)
      rd(OFS_ISR_HI, 8'h00);
      $display("test lock and pass done");
      report_and_stop();
   end
endmodule // tb_rpia_top
bind rpia_top rpia_checker #(.NUM_PORTS(NUM_PORTS)) i_rpia_checker (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .link_locked_i(link_locked_i), .pass_i(pass_i),
   .link_parity_err_i(link_parity_err_i), .link_encode_err_i(link_encode_err_i),
   .backchan_checksum_err_i(backchan_checksum_err_i),
   .backchan_sequence_err_i(backchan_sequence_err_i), .irq_out_n_o(irq_out_n_o));
